/* pkg/epm_pkg.sv */
package epm_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADR_W = 16;
  localparam int IDX_W = 14;
  localparam int IDX_LSB = 2;

  typedef logic [DATA_W-1:0] epm_data_t;
  typedef logic [ADR_W-1:0] epm_adr_t;
  typedef logic [IDX_W-1:0] epm_idx_t;
  typedef logic [7:0] epm_byte_t;

  // Register indices; byte address is four times the index
  localparam epm_idx_t IDX_FE_HIGH = 14'h0907;
  localparam epm_idx_t IDX_FE_LOW = 14'h0908;
  localparam epm_idx_t IDX_RX_SLIP = 14'h0909;
  localparam epm_idx_t IDX_FRAME_LOSS = 14'h090a;
  localparam epm_idx_t IDX_ALIGN_CHG = 14'h090b;
  localparam epm_idx_t IDX_LINK1_FCS = 14'h090c;
  localparam epm_idx_t IDX_TP_HIGH = 14'h090d;
  localparam epm_idx_t IDX_TP_LOW = 14'h090e;
  localparam epm_idx_t IDX_TX_SLIP = 14'h090f;
  localparam epm_idx_t IDX_CTRL = 14'h0920;
  localparam epm_idx_t IDX_STATUS = 14'h0921;

  // Positions of the 8-bit counters in the byte counter array
  localparam int NUM_BYTE_CNT = 5;
  localparam int BC_RX_SLIP = 0;
  localparam int BC_TX_SLIP = 1;
  localparam int BC_FRAME_LOSS = 2;
  localparam int BC_ALIGN_CHG = 3;
  localparam int BC_LINK1_FCS = 4;

  // Positions of the 16-bit counters in the wide counter array
  localparam int NUM_WIDE_CNT = 2;
  localparam int WC_FAR_END = 0;
  localparam int WC_TEST_PAT = 1;
  localparam int BYTE_W = 8;
  localparam int WIDE_W = 16;

  // Control register fields and reset value
  localparam int CTRL_COUNT_EN = 0;
  localparam int CTRL_SATURATE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status register fields
  localparam int STAT_FE_PEND = 0;
  localparam int STAT_TP_PEND = 1;
  localparam int STAT_SYNC_LOST = 2;

  localparam epm_data_t DATA_ZERO = 32'h0000_0000;
  localparam epm_byte_t BYTE_ZERO = 8'h00;

endpackage : epm_pkg

/* pkg/epm_cnt_if.sv */
`timescale 1ns/1ps

// Count request and live value between the bank and one counter
interface epm_cnt_if #(parameter int W = 8);
  logic inc;
  logic clr;
  logic [W-1:0] count;
  modport counter (input inc, input clr, output count);
  modport user (output inc, output clr, input count);
endinterface : epm_cnt_if

/* logic/epm_event_counter.sv */
`timescale 1ns/1ps

module epm_event_counter #(parameter int W = 8) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic saturate,
  epm_cnt_if.counter cnt
);

  logic [W-1:0] count_q;

  // Clear on read; an event in the clearing cycle starts the new period at one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (cnt.clr) begin
      count_q <= cnt.inc ? W'(1) : '0;
    end else if (cnt.inc && !(saturate && (&count_q))) begin
      count_q <= count_q + W'(1);
    end
  end

  assign cnt.count = count_q;

endmodule : epm_event_counter

/* logic/epm_pair_latch.sv */
`timescale 1ns/1ps

module epm_pair_latch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hi_rd,
  input wire logic lo_rd,
  input wire epm_pkg::epm_byte_t live_low,
  output epm_pkg::epm_byte_t low_byte,
  output logic pending
);
  import epm_pkg::*;

  epm_byte_t low_q;
  logic pend_q;

  // Lower half frozen when the upper half is read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_q <= BYTE_ZERO;
    end else if (hi_rd) begin
      low_q <= live_low;
    end
  end

  // Marks a frozen lower half not yet collected
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (hi_rd) begin
      pend_q <= 1'b1;
    end else if (lo_rd) begin
      pend_q <= 1'b0;
    end
  end

  assign low_byte = pend_q ? low_q : live_low;
  assign pending = pend_q;

endmodule : epm_pair_latch

/* logic/epm_perf_monitor.sv */
`timescale 1ns/1ps

// Summary of operation
// - Far-end block error count rises by one per received E-bit equal to zero.
// - Far-end count is frozen while frame alignment or CRC-4 multiframe sync is lost.
// - Loss of signalling multiframe alignment alone does not stop far-end counting.
// - Far-end count is 16 bits, read as an upper and a lower byte.
// - Each counter holds events since its last clearing read (the upper byte of a 16-bit counter) and clears on that read.
// - Receive slip counter (8 bits) counts each frame repeated or dropped on receive.
// - Transmit slip counter (8 bits) counts each frame repeated or dropped on transmit.
// - Frame loss counter (8 bits) counts each new loss-of-frame declaration.
// - Alignment change counter (8 bits) counts locks differing from the off-line candidate.
// - Link 1 checksum error counter (8 bits) counts each frame check sequence error.
// - Test pattern error count is 16 bits, upper and lower byte, per bit error.
module epm_perf_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire epm_pkg::epm_adr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire epm_pkg::epm_data_t wb_dat_i,
  output epm_pkg::epm_data_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic e_bit_valid,
  input wire logic e_bit_value,
  input wire logic fas_sync_lost,
  input wire logic crc_mf_sync_lost,
  input wire logic rx_slip_event,
  input wire logic tx_slip_event,
  input wire logic frame_loss_state,
  input wire logic alignment_change_event,
  input wire logic link1_fcs_err,
  input wire logic test_pattern_err_event
);
  import epm_pkg::*;

  // Zero-extends a byte into a bus word
  function automatic epm_data_t byte_word(input epm_byte_t b);
    byte_word = {{(DATA_W-BYTE_W){1'b0}}, b};
  endfunction : byte_word

  // True when a taken read addresses the given register
  function automatic logic read_hits(input logic take, input epm_idx_t at, input epm_idx_t want);
    read_hits = take && (at == want);
  endfunction : read_hits

  logic ack_q;
  epm_data_t dat_q;
  epm_data_t rdata_d;
  logic [CTRL_SATURATE:CTRL_COUNT_EN] ctrl_q;
  logic frame_loss_q;
  logic req_take;
  logic rd_take;
  logic wr_take;
  epm_idx_t idx;
  logic count_en;
  logic [NUM_BYTE_CNT-1:0] byte_inc;
  logic [NUM_BYTE_CNT-1:0] byte_clr;
  epm_byte_t byte_cnt [NUM_BYTE_CNT];
  logic [NUM_WIDE_CNT-1:0] wide_inc;
  logic [NUM_WIDE_CNT-1:0] wide_hi_rd;
  logic [NUM_WIDE_CNT-1:0] wide_lo_rd;
  logic [WIDE_W-1:0] wide_cnt [NUM_WIDE_CNT];
  epm_byte_t wide_low [NUM_WIDE_CNT];
  logic [NUM_WIDE_CNT-1:0] wide_pend;

  // Request taken once per cycle; ack blocks a second take of the same request
  assign req_take = wb_cyc_i & wb_stb_i & ~ack_q;
  assign rd_take = req_take & ~wb_we_i;
  assign wr_take = req_take & wb_we_i;
  assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
  assign count_en = ctrl_q[CTRL_COUNT_EN];

  // Event conditioning for the far-end and test pattern counters
  assign wide_inc[WC_FAR_END] = count_en & e_bit_valid & ~e_bit_value
                                & ~fas_sync_lost & ~crc_mf_sync_lost;
  assign wide_inc[WC_TEST_PAT] = count_en & test_pattern_err_event;

  // Event conditioning for the byte counters
  assign byte_inc[BC_RX_SLIP] = count_en & rx_slip_event;
  assign byte_inc[BC_TX_SLIP] = count_en & tx_slip_event;
  assign byte_inc[BC_FRAME_LOSS] = count_en & frame_loss_state & ~frame_loss_q;
  assign byte_inc[BC_ALIGN_CHG] = count_en & alignment_change_event;
  assign byte_inc[BC_LINK1_FCS] = count_en & link1_fcs_err;

  // Clearing reads of each counter
  assign byte_clr[BC_RX_SLIP] = read_hits(rd_take, idx, IDX_RX_SLIP);
  assign byte_clr[BC_TX_SLIP] = read_hits(rd_take, idx, IDX_TX_SLIP);
  assign byte_clr[BC_FRAME_LOSS] = read_hits(rd_take, idx, IDX_FRAME_LOSS);
  assign byte_clr[BC_ALIGN_CHG] = read_hits(rd_take, idx, IDX_ALIGN_CHG);
  assign byte_clr[BC_LINK1_FCS] = read_hits(rd_take, idx, IDX_LINK1_FCS);
  assign wide_hi_rd[WC_FAR_END] = read_hits(rd_take, idx, IDX_FE_HIGH);
  assign wide_hi_rd[WC_TEST_PAT] = read_hits(rd_take, idx, IDX_TP_HIGH);
  assign wide_lo_rd[WC_FAR_END] = read_hits(rd_take, idx, IDX_FE_LOW);
  assign wide_lo_rd[WC_TEST_PAT] = read_hits(rd_take, idx, IDX_TP_LOW);

  // Previous loss-of-frame level, for catching each new declaration
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_loss_q <= 1'b0;
    end else begin
      frame_loss_q <= frame_loss_state;
    end
  end

  // Byte-wide counters
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTE_CNT; gi++) begin : g_byte
      epm_cnt_if #(.W(BYTE_W)) bif ();
      assign bif.inc = byte_inc[gi];
      assign bif.clr = byte_clr[gi];
      assign byte_cnt[gi] = bif.count;
      epm_event_counter #(.W(BYTE_W)) u_cnt (
        .core_clk(core_clk),
        .rst(rst),
        .saturate(ctrl_q[CTRL_SATURATE]),
        .cnt(bif)
      );
    end
  endgenerate

  // 16-bit counters with their lower-byte latches
  generate
    for (gi = 0; gi < NUM_WIDE_CNT; gi++) begin : g_wide
      epm_cnt_if #(.W(WIDE_W)) wif ();
      assign wif.inc = wide_inc[gi];
      assign wif.clr = wide_hi_rd[gi];
      assign wide_cnt[gi] = wif.count;
      epm_event_counter #(.W(WIDE_W)) u_cnt (
        .core_clk(core_clk),
        .rst(rst),
        .saturate(ctrl_q[CTRL_SATURATE]),
        .cnt(wif)
      );
      epm_pair_latch u_latch (
        .core_clk(core_clk),
        .rst(rst),
        .hi_rd(wide_hi_rd[gi]),
        .lo_rd(wide_lo_rd[gi]),
        .live_low(wide_cnt[gi][BYTE_W-1:0]),
        .low_byte(wide_low[gi]),
        .pending(wide_pend[gi])
      );
    end
  endgenerate

  // Control register: count enable and saturate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_take && (idx == IDX_CTRL) && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[CTRL_SATURATE:CTRL_COUNT_EN];
    end
  end

  // Read data selection; unmapped addresses read as zero
  always_comb begin
    rdata_d = DATA_ZERO;
    case (idx)
      IDX_FE_HIGH: rdata_d = byte_word(wide_cnt[WC_FAR_END][WIDE_W-1:BYTE_W]);
      IDX_FE_LOW: rdata_d = byte_word(wide_low[WC_FAR_END]);
      IDX_TP_HIGH: rdata_d = byte_word(wide_cnt[WC_TEST_PAT][WIDE_W-1:BYTE_W]);
      IDX_TP_LOW: rdata_d = byte_word(wide_low[WC_TEST_PAT]);
      IDX_RX_SLIP: rdata_d = byte_word(byte_cnt[BC_RX_SLIP]);
      IDX_TX_SLIP: rdata_d = byte_word(byte_cnt[BC_TX_SLIP]);
      IDX_FRAME_LOSS: rdata_d = byte_word(byte_cnt[BC_FRAME_LOSS]);
      IDX_ALIGN_CHG: rdata_d = byte_word(byte_cnt[BC_ALIGN_CHG]);
      IDX_LINK1_FCS: rdata_d = byte_word(byte_cnt[BC_LINK1_FCS]);
      IDX_CTRL: rdata_d = {{(DATA_W-CTRL_SATURATE-1){1'b0}}, ctrl_q};
      IDX_STATUS: begin
        rdata_d[STAT_FE_PEND] = wide_pend[WC_FAR_END];
        rdata_d[STAT_TP_PEND] = wide_pend[WC_TEST_PAT];
        rdata_d[STAT_SYNC_LOST] = fas_sync_lost | crc_mf_sync_lost;
      end
      default: rdata_d = DATA_ZERO;
    endcase
  end

  // Acknowledge one cycle after the request is taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_take;
    end
  end

  // Read data register, loaded when any request is taken; a taken write loads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dat_q <= DATA_ZERO;
    end else if (req_take) begin
      dat_q <= wb_we_i ? DATA_ZERO : rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule : epm_perf_monitor

/* tb/epm_perf_monitor_asserts.sv */
`timescale 1ns/1ps
module epm_perf_monitor_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire epm_pkg::epm_adr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire epm_pkg::epm_data_t wb_dat_i,
  input wire epm_pkg::epm_data_t wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic e_bit_valid,
  input wire logic e_bit_value,
  input wire logic fas_sync_lost,
  input wire logic crc_mf_sync_lost,
  input wire logic rx_slip_event,
  input wire logic tx_slip_event,
  input wire logic frame_loss_state,
  input wire logic alignment_change_event,
  input wire logic link1_fcs_err,
  input wire logic test_pattern_err_event
);
  import epm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  logic rd_take;
  epm_idx_t idx;
  logic slip_seen_q;
  // Request taken at this edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_take = take && !wb_we_i;
  assign idx = wb_adr_i[15:2];
  // Remembers a receive slip since the last clearing read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slip_seen_q <= 1'b0;
    end else if (rx_slip_event) begin
      slip_seen_q <= 1'b1;
    end else if (rd_take && idx == IDX_RX_SLIP) begin
      slip_seen_q <= 1'b0;
    end
  end
  a_ack_follows_req: assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  a_byte_wide_data: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper data bits set");
  a_data_holds: assert property (!$past(take) |-> $stable(wb_dat_o)) else $error("read data moved");
  a_unmapped_zero: assert property (rd_take && (idx < IDX_FE_HIGH || idx > IDX_STATUS) |=> wb_dat_o == DATA_ZERO)
    else $error("unmapped read not zero");
  a_read_clears: assert property (rd_take && idx == IDX_RX_SLIP && !slip_seen_q && !rx_slip_event
    |=> wb_dat_o == DATA_ZERO) else $error("count not cleared by read");
  a_status_sync: assert property (rd_take && idx == IDX_STATUS && fas_sync_lost && $past(fas_sync_lost)
    |=> wb_dat_o[STAT_SYNC_LOST]) else $error("sync lost not shown");
  c_read: cover property (rd_take);
  c_write: cover property (take && wb_we_i);
  c_collide: cover property (rd_take && idx == IDX_RX_SLIP && rx_slip_event);
endmodule : epm_perf_monitor_asserts

bind epm_perf_monitor epm_perf_monitor_asserts chk_u (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .e_bit_valid(e_bit_valid), .e_bit_value(e_bit_value),
  .fas_sync_lost(fas_sync_lost), .crc_mf_sync_lost(crc_mf_sync_lost), .rx_slip_event(rx_slip_event),
  .tx_slip_event(tx_slip_event), .frame_loss_state(frame_loss_state),
  .alignment_change_event(alignment_change_event), .link1_fcs_err(link1_fcs_err),
  .test_pattern_err_event(test_pattern_err_event));

/* tb/epm_perf_monitor_tb.sv */
`timescale 1ns/1ps
module epm_perf_monitor_tb;
  import epm_pkg::*;
  logic core_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, ebv, fas, crc, floss;
  epm_adr_t wb_adr;
  epm_data_t wb_wdat, wb_rdat, rd;
  logic [5:0] ev;
  logic [3:0] wb_sel, lanes;
  int failures, checked;
  epm_perf_monitor dut_u (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .e_bit_valid(ev[5]), .e_bit_value(ebv), .fas_sync_lost(fas), .crc_mf_sync_lost(crc), .rx_slip_event(ev[0]),
    .tx_slip_event(ev[1]), .frame_loss_state(floss), .alignment_change_event(ev[2]), .link1_fcs_err(ev[3]),
    .test_pattern_err_event(ev[4]));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One classic cycle; hit pulses events at the edge that takes the request
  task automatic bus(input logic we, input epm_idx_t idx, input epm_data_t wd, input logic [5:0] hit);
    int i;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= wd;
    wb_sel <= lanes;
    ev <= hit;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      ev <= 6'h00;
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      tally_and_finish();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  task automatic rdchk(input string what, input epm_idx_t idx, input epm_data_t exp);
    bus(1'b0, idx, DATA_ZERO, 6'h00);
    chk(what, rd, exp);
  endtask : rdchk
  // Back-to-back event pulses
  task automatic fire(input logic [5:0] m, input int n, input logic v);
    repeat (n) begin
      @(posedge core_clk);
      ev <= m;
      ebv <= v;
    end
    @(posedge core_clk);
    ev <= 6'h00;
  endtask : fire
  task automatic t_reset();
    for (int k = 0; k < 9; k++) begin
      rdchk("reset count", epm_idx_t'(IDX_FE_HIGH + k), DATA_ZERO);
    end
    rdchk("ctrl reset", IDX_CTRL, 32'h0000_0001);
    $display("reset test done");
  endtask : t_reset
  task automatic t_bytes();
    epm_idx_t ix[4] = '{IDX_RX_SLIP, IDX_TX_SLIP, IDX_ALIGN_CHG, IDX_LINK1_FCS};
    fire(6'h0f, 5, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      floss <= 1'b1;
      repeat (3) @(posedge core_clk);
      floss <= 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      rdchk("byte count", ix[k], 32'h0000_0005);
      rdchk("after read", ix[k], DATA_ZERO);
    end
    rdchk("frame loss", IDX_FRAME_LOSS, 32'h0000_0002);
    fire(6'h01, 3, 1'b1);
    bus(1'b0, IDX_RX_SLIP, DATA_ZERO, 6'h01);
    chk("slip before clear", rd, 32'h0000_0003);
    rdchk("slip at clear", IDX_RX_SLIP, 32'h0000_0001);
    $display("byte counter test done");
  endtask : t_bytes
  task automatic t_far_end();
    fire(6'h20, 4, 1'b0);
    fire(6'h20, 3, 1'b1);
    @(posedge core_clk);
    fas <= 1'b1;
    fire(6'h20, 2, 1'b0);
    rdchk("status sync", IDX_STATUS, 32'h0000_0004);
    fas <= 1'b0;
    crc <= 1'b1;
    fire(6'h20, 2, 1'b0);
    crc <= 1'b0;
    rdchk("far end high", IDX_FE_HIGH, DATA_ZERO);
    rdchk("low pending", IDX_STATUS, 32'h0000_0001);
    rdchk("far end low", IDX_FE_LOW, 32'h0000_0004);
    fire(6'h10, 300, 1'b1);
    rdchk("pattern high", IDX_TP_HIGH, 32'h0000_0001);
    rdchk("tp pending", IDX_STATUS, 32'h0000_0002);
    fire(6'h10, 2, 1'b1);
    rdchk("pattern low", IDX_TP_LOW, 32'h0000_002c);
    rdchk("pattern high 2", IDX_TP_HIGH, DATA_ZERO);
    rdchk("pattern low 2", IDX_TP_LOW, 32'h0000_0002);
    $display("wide counter test done");
  endtask : t_far_end
  task automatic t_ctrl();
    bus(1'b1, IDX_CTRL, DATA_ZERO, 6'h00);
    fire(6'h01, 2, 1'b1);
    rdchk("count disabled", IDX_RX_SLIP, DATA_ZERO);
    bus(1'b1, IDX_CTRL, 32'h0000_0003, 6'h00);
    fire(6'h02, 260, 1'b1);
    rdchk("saturated", IDX_TX_SLIP, 32'h0000_00ff);
    bus(1'b1, IDX_CTRL, 32'h0000_0001, 6'h00);
    fire(6'h02, 257, 1'b1);
    rdchk("wrapped", IDX_TX_SLIP, 32'h0000_0001);
    lanes = 4'he;
    bus(1'b1, IDX_CTRL, DATA_ZERO, 6'h00);
    lanes = 4'hf;
    rdchk("lane ignored", IDX_CTRL, 32'h0000_0001);
    rdchk("unmapped", 14'h0930, DATA_ZERO);
    $display("control test done");
  endtask : t_ctrl
  // Main sequence
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, ebv, fas, crc, floss} = 8'hff;
    {wb_cyc, wb_stb, wb_we, ebv, fas, crc, floss} = 7'h00;
    {wb_adr, wb_wdat, ev} = '0;
    {wb_sel, lanes} = 8'hff;
    failures = 0;
    checked = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_bytes();
    t_far_end();
    t_ctrl();
    tally_and_finish();
  end
endmodule : epm_perf_monitor_tb
